// >>> ocf_defines.svh
`ifndef OCF_DEFINES_SVH
`define OCF_DEFINES_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define OCF_CMD_RESP 8'h47
`define OCF_CMD_WARN 8'h4A
`define OCF_CMD_OTF 8'h4F
`define OCF_PHASE_ALL 8'hFF

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define OCF_ACT_MSB 7
`define OCF_ACT_LSB 6
`define OCF_RETRY_MSB 5
`define OCF_RETRY_LSB 3
`define OCF_DELAY_MSB 2
`define OCF_DELAY_LSB 0
`define OCF_EXP_MSB 15
`define OCF_EXP_LSB 11
`define OCF_WARN_EXP 5'h1E
`define OCF_RESP_RST 8'hC0
`define OCF_WARN_QA_RST 8'hA0
`define OCF_OT_RST 16'h007D

// ----------------------------------------
// Limits in quarter amps, 2 A steps and timing
// ----------------------------------------
`define OCF_QA_MAX 8'hF8
`define OCF_STEP_MIN 5'h04
`define OCF_SD_TICKS_A 3'h1
`define OCF_SD_TICKS_B 3'h3
`define OCF_SD_TICKS_C 3'h7
`define OCF_RETRY_FOREVER 3'h7
`define OCF_CLK_MHZ 50
`define OCF_TON_RISE_US 1000
`endif

// >>> ocf_host.sv
`timescale 1ns/10ps
// Command source standing in for the bus engine
module ocf_host (
    input wire logic clk,
    output logic valid,
    output logic write,
    output logic word,
    output logic [7:0] code,
    output logic [7:0] phase,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic rdata_valid
);
    // Idle bus at time zero
    initial begin
        valid = 1'b0;
        write = 1'b0;
        word = 1'b0;
        code = 8'h00;
        phase = 8'h00;
        wdata = 16'h0000;
    end
    // One transfer, read data taken with its valid flag
    task automatic xfer(input logic w, input logic wd, input logic [7:0] c,
        input logic [7:0] p, input logic [15:0] d, output logic [15:0] r);
        @(negedge clk);
        valid = 1'b1;
        write = w;
        word = wd;
        code = c;
        phase = p;
        wdata = d;
        @(negedge clk);
        valid = 1'b0;
        wdata = ~d; // No stale data after release
        r = rdata_valid ? rdata : 16'hxxxx;
    endtask : xfer
endmodule : ocf_host

// >>> ocf_pkg.sv
package ocf_pkg;
    // Restart sequencer states
    typedef enum logic [2:0] {
        OCF_OFF,
        OCF_SOFTSTART,
        OCF_RUN,
        OCF_DELAY,
        OCF_RESTART_WAIT_PERIOD,
        OCF_LATCH
    } ocf_state_e;
    // Quarter-amp count of one phase
    typedef logic [7:0] ocf_qa_t;
endpackage : ocf_pkg

// >>> ocf_restart_ctl.sv
`timescale 1ns/10ps
`include "ocf_defines.svh"
module ocf_restart_ctl import ocf_pkg::*; #(
    parameter int TON_RISE_CYCLES = `OCF_TON_RISE_US * `OCF_CLK_MHZ
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic fault,
    input wire logic pwm_tick,
    input wire logic [1:0] action,
    input wire logic [2:0] retries,
    input wire logic [2:0] delay_code,
    output logic power_on,
    output logic latched
);
    ocf_state_e state, next_state;
    logic [23:0] timer, next_timer;
    logic [2:0] units, next_units;
    logic [2:0] tries, next_tries;
    logic [2:0] sd_len, hic_len;
    logic shut;

    // ----------------------------------------
    // Delay code decode
    // ----------------------------------------
    always_comb begin
        if (delay_code <= 3'h1) begin
            sd_len = `OCF_SD_TICKS_A;
            hic_len = 3'h1;
        end else if (delay_code <= 3'h4) begin
            sd_len = `OCF_SD_TICKS_B;
            hic_len = delay_code;
        end else begin
            sd_len = `OCF_SD_TICKS_C;
            hic_len = delay_code;
        end
    end

    // ----------------------------------------
    // Next state of the sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_units = units;
        next_tries = tries;
        shut = 1'b0;
        case (state)
            OCF_OFF: begin
                next_timer = 24'h0000;
                next_tries = 3'h0;
                if (enable) begin
                    next_state = OCF_SOFTSTART;
                end
            end
            OCF_SOFTSTART, OCF_RUN: begin
                if (fault && action == 2'b10) begin
                    next_state = OCF_DELAY;
                    next_units = 3'h0;
                end else if (fault && action == 2'b11) begin
                    shut = 1'b1;
                end else if (state == OCF_SOFTSTART) begin
                    if (timer == 24'(TON_RISE_CYCLES - 1)) begin
                        next_state = OCF_RUN; // Start-up succeeded
                        next_tries = 3'h0;
                        next_timer = 24'h0000;
                    end else begin
                        next_timer = timer + 24'h0001;
                    end
                end
            end
            OCF_DELAY: begin
                if (fault && action == 2'b11) begin
                    shut = 1'b1;
                end else if (pwm_tick) begin
                    if (units == sd_len - 3'h1) begin
                        shut = 1'b1;
                    end else begin
                        next_units = units + 3'h1;
                    end
                end
            end
            OCF_RESTART_WAIT_PERIOD: begin
                if (timer == 24'(TON_RISE_CYCLES - 1)) begin
                    next_timer = 24'h0000;
                    if (units == hic_len - 3'h1) begin
                        next_state = OCF_SOFTSTART;
                    end else begin
                        next_units = units + 3'h1;
                    end
                end else begin
                    next_timer = timer + 24'h0001;
                end
            end
            OCF_LATCH: begin
                next_state = OCF_LATCH;
            end
            default: begin
                next_state = OCF_OFF;
            end
        endcase
        if (shut) begin
            next_timer = 24'h0000;
            next_units = 3'h0;
            if (retries == 3'h0) begin
                next_state = OCF_LATCH;
            end else if (retries != `OCF_RETRY_FOREVER && tries == retries) begin
                next_state = OCF_LATCH;
            end else begin
                next_state = OCF_RESTART_WAIT_PERIOD;
                if (tries != `OCF_RETRY_FOREVER) begin
                    next_tries = tries + 3'h1;
                end
            end
        end
        if (!enable) begin
            next_state = OCF_OFF;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= OCF_OFF;
            timer <= 24'h0000;
            units <= 3'h0;
            tries <= 3'h0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            units <= next_units;
            tries <= next_tries;
        end
    end

    // Output keeps running through the shutdown delay
    assign power_on = (state == OCF_SOFTSTART) || (state == OCF_RUN) || (state == OCF_DELAY);
    assign latched = (state == OCF_LATCH);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_shut_immediate: assert property (@(posedge clk) disable iff (reset)
        (power_on && enable && fault && action == 2'b11) |=> !power_on)
        else $error("immediate shutdown missed");
    a_ignore_fault: assert property (@(posedge clk) disable iff (reset)
        (state == OCF_RUN && enable && !action[1]) |=> power_on)
        else $error("ignored fault stopped output");
    a_latch_zero: assert property (@(posedge clk) disable iff (reset)
        (power_on && enable && fault && action == 2'b11 && retries == 3'h0) |=> latched)
        else $error("retry zero did not latch");
    a_retry_forever: assert property (@(posedge clk) disable iff (reset)
        (power_on && enable && fault && action == 2'b11 && retries == 3'h7)
        |=> state == OCF_RESTART_WAIT_PERIOD)
        else $error("endless retry stopped");
    a_delay_short: assert property (@(posedge clk) disable iff (reset)
        (state == OCF_DELAY && delay_code <= 3'h1 && pwm_tick && enable)
        |=> state != OCF_DELAY)
        else $error("short shutdown delay too long");
endmodule : ocf_restart_ctl

// >>> ocf_top.sv
`timescale 1ns/10ps
`include "ocf_defines.svh"
module ocf_top import ocf_pkg::*; #(
    parameter int NUM_PHASES = 4,
    parameter int TON_RISE_CYCLES = `OCF_TON_RISE_US * `OCF_CLK_MHZ
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic CMD_WORD,
    input wire logic [7:0] CMD_CODE,
    input wire logic [7:0] PHASE,
    input wire logic [15:0] CMD_WDATA,
    output logic [15:0] RDATA,
    output logic RDATA_VALID,
    input wire logic CLEAR_FAULTS,
    input wire logic NVM_RESTORE,
    input wire logic [7:0] NVM_RESP,
    input wire logic [15:0] NVM_WARN,
    input wire logic [15:0] NVM_OT,
    input wire logic PWM_TICK,
    input wire logic ENABLE,
    input wire logic [NUM_PHASES*11-1:0] PHASE_IOUT,
    input wire logic [10:0] CURRENT_FAULT_THRESHOLD,
    input wire logic [11:0] DIE_TEMP,
    output logic POWER_ON,
    output logic LATCHED_OFF,
    output logic [NUM_PHASES*5-1:0] PHASE_WARN_STEP,
    output logic [NUM_PHASES-1:0] PHASE_WARN,
    output logic STAT_BYTE_IOUT_OC,
    output logic STAT_BYTE_NONE,
    output logic STAT_WORD_IOUT,
    output logic STAT_IOUT_OCF,
    output logic STAT_IOUT_OCW,
    output logic STAT_TEMP_OTF,
    output logic STAT_CML_DATA,
    output logic NOTIFY_HOST
);
    // ----------------------------------------
    // Linear format helpers
    // ----------------------------------------
    // Unsigned value in quarter amps, rounded up or to nearest
    function automatic logic [31:0] lin_to_qa(input logic [15:0] w, input logic nearest);
        logic signed [5:0] sh;
        logic [31:0] m;
        logic [31:0] r;
        // Two fraction bits give quarter amps
        sh = $signed({w[15], w[15:11]}) + 6'sd2;
        m = {21'h0, w[10:0]};
        if (sh >= 6'sd0) begin
            r = m << sh;
        end else if (nearest) begin
            r = (m + (32'h1 << (-sh - 6'sd1))) >> (-sh);
        end else begin
            r = (m + (32'h1 << (-sh)) - 32'h1) >> (-sh);
        end
        return r;
    endfunction : lin_to_qa

    // Signed value in whole degrees
    function automatic logic signed [31:0] lin_to_deg(input logic [15:0] w);
        logic signed [31:0] m;
        logic signed [5:0] e;
        m = 32'($signed(w[10:0]));
        e = $signed({w[15], w[15:11]});
        if (e >= 6'sd0) begin
            return m <<< e;
        end else begin
            return m >>> (-e);
        end
    endfunction : lin_to_deg

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // Decoded strobes and refusal reasons
    logic wr, rd, hit_resp, hit_warn, hit_ot, all_ph, ph_ok, bad_size;
    logic warn_bad, ot_bad, invalid, warn_wr;
    logic [31:0] wq, per_qa, nvm_qa;
    logic signed [31:0] ot_val;
    ocf_qa_t wr_qa, rs_qa;
    int ph_idx;

    always_comb begin
        wr = CMD_VALID && CMD_WRITE;
        rd = CMD_VALID && !CMD_WRITE;
        hit_resp = (CMD_CODE == `OCF_CMD_RESP);
        hit_warn = (CMD_CODE == `OCF_CMD_WARN);
        hit_ot = (CMD_CODE == `OCF_CMD_OTF);
        all_ph = (PHASE == `OCF_PHASE_ALL);
        ph_idx = int'(PHASE);
        ph_ok = all_ph || (ph_idx < NUM_PHASES);
        bad_size = (hit_resp && CMD_WORD) || ((hit_warn || hit_ot) && !CMD_WORD);
        // Written limit per phase, rounded up
        wq = lin_to_qa(CMD_WDATA, 1'b0);
        per_qa = all_ph ? (wq + 32'(NUM_PHASES - 1)) / 32'(NUM_PHASES) : wq;
        warn_bad = CMD_WDATA[10] || !ph_ok || per_qa > 32'(`OCF_QA_MAX);
        // Temperature limit must fit a die reading
        ot_val = lin_to_deg(CMD_WDATA);
        ot_bad = (ot_val > 32'sd2047) || (ot_val < -32'sd2048);
        invalid = CMD_VALID && (bad_size || (hit_warn && !ph_ok)
                  || (wr && hit_warn && warn_bad) || (wr && hit_ot && ot_bad));
        warn_wr = wr && hit_warn && !invalid;
        wr_qa = per_qa[7:0];
        // Restored limit, nearest quarter amp, capped
        nvm_qa = lin_to_qa(NVM_WARN, 1'b1);
        if (NVM_WARN[10] || nvm_qa > 32'(`OCF_QA_MAX)) begin
            rs_qa = `OCF_QA_MAX;
        end else begin
            rs_qa = nvm_qa[7:0];
        end
    end

    // ----------------------------------------
    // Response and temperature limit registers
    // ----------------------------------------
    // Response byte and raw temperature limit
    logic [7:0] resp, next_resp;
    logic [15:0] ot_raw, next_ot_raw;

    always_comb begin
        next_resp = resp;
        next_ot_raw = ot_raw;
        if (NVM_RESTORE) begin
            next_resp = NVM_RESP;
            next_ot_raw = NVM_OT;
        end else if (wr && !invalid) begin
            if (hit_resp) begin
                // Delay field is read only
                next_resp = {CMD_WDATA[7:3], resp[2:0]};
            end else if (hit_ot) begin
                next_ot_raw = CMD_WDATA;
            end
        end
    end

    // Response and limit registers
    always_ff @(posedge CLK) begin
        if (RESET) begin
            resp <= `OCF_RESP_RST;
            ot_raw <= `OCF_OT_RST;
        end else begin
            resp <= next_resp;
            ot_raw <= next_ot_raw;
        end
    end

    // ----------------------------------------
    // Per-phase warning limit and detection
    // ----------------------------------------
    // Stored limits gathered for the read path
    logic [NUM_PHASES*8-1:0] lim_vec;
    logic [NUM_PHASES-1:0] warn_trip, oc_trip;

    genvar g;
    generate
        for (g = 0; g < NUM_PHASES; g++) begin : g_phase
            ocf_qa_t lim, next_lim;
            logic [4:0] step, next_step;
            logic warn, next_warn;
            logic [10:0] iout;
            logic [7:0] up;

            // Current of this phase in quarter amps
            assign iout = PHASE_IOUT[g*11 +: 11];

            // Limit storage and hardware step
            always_comb begin
                next_lim = lim;
                if (NVM_RESTORE) begin
                    next_lim = rs_qa;
                end else if (warn_wr && (all_ph || ph_idx == g)) begin
                    next_lim = wr_qa;
                end
                up = lim + 8'h07;
                next_step = (up[7:3] < `OCF_STEP_MIN) ? `OCF_STEP_MIN : up[7:3];
                next_warn = warn_trip[g] || (warn && !CLEAR_FAULTS);
            end

            // Limit, applied step and sticky warning
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    lim <= `OCF_WARN_QA_RST;
                    step <= `OCF_STEP_MIN;
                    warn <= 1'b0;
                end else begin
                    lim <= next_lim;
                    step <= next_step;
                    warn <= next_warn;
                end
            end

            // Each phase compares with its own step
            assign warn_trip[g] = (iout >= {3'h0, step, 3'h0});
            assign oc_trip[g] = (iout >= CURRENT_FAULT_THRESHOLD);
            assign lim_vec[g*8 +: 8] = lim;
            assign PHASE_WARN_STEP[g*5 +: 5] = step;
            assign PHASE_WARN[g] = warn;
        end
    endgenerate

    // ----------------------------------------
    // Fault restart sequencer
    // ----------------------------------------
    // Fault detectors feeding status; only the current fault feeds the sequencer
    logic oc_fault, ot_fault;
    assign oc_fault = |oc_trip;
    assign ot_fault = $signed(32'($signed(DIE_TEMP))) >= lin_to_deg(ot_raw);

    // Shutdown, delay and restart of the output
    ocf_restart_ctl #(
        .TON_RISE_CYCLES(TON_RISE_CYCLES)
    ) ocf_restart_ctl_i (
        .clk(CLK),
        .reset(RESET),
        .enable(ENABLE),
        .fault(oc_fault),
        .pwm_tick(PWM_TICK),
        .action(resp[`OCF_ACT_MSB:`OCF_ACT_LSB]),
        .retries(resp[`OCF_RETRY_MSB:`OCF_RETRY_LSB]),
        .delay_code(resp[`OCF_DELAY_MSB:`OCF_DELAY_LSB]),
        .power_on(POWER_ON),
        .latched(LATCHED_OFF)
    );

    // ----------------------------------------
    // Sticky status, set wins over clear
    // ----------------------------------------
    // Sticky fault and data flags
    logic st_ocf, st_otf, st_cml;
    logic next_st_ocf, next_st_otf, next_st_cml;

    // Next value of each sticky flag
    always_comb begin
        next_st_ocf = oc_fault || (st_ocf && !CLEAR_FAULTS);
        next_st_otf = ot_fault || (st_otf && !CLEAR_FAULTS);
        next_st_cml = invalid || (st_cml && !CLEAR_FAULTS);
    end

    // Sticky flag registers
    always_ff @(posedge CLK) begin
        if (RESET) begin
            st_ocf <= 1'b0;
            st_otf <= 1'b0;
            st_cml <= 1'b0;
        end else begin
            st_ocf <= next_st_ocf;
            st_otf <= next_st_otf;
            st_cml <= next_st_cml;
        end
    end

    // Status outputs and host notification
    assign STAT_IOUT_OCF = st_ocf;
    assign STAT_BYTE_IOUT_OC = st_ocf;
    assign STAT_IOUT_OCW = |PHASE_WARN;
    assign STAT_BYTE_NONE = |PHASE_WARN;
    assign STAT_WORD_IOUT = st_ocf || (|PHASE_WARN);
    assign STAT_TEMP_OTF = st_otf;
    assign STAT_CML_DATA = st_cml;
    assign NOTIFY_HOST = st_ocf || st_otf || st_cml || (|PHASE_WARN);

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Read data for the following cycle
    logic [15:0] next_rdata;
    logic [10:0] sum_qa;

    // Selects read data of the addressed command
    always_comb begin
        sum_qa = 11'(lim_vec[7:0] * NUM_PHASES);
        next_rdata = 16'h0000;
        if (rd && !invalid) begin
            if (hit_resp) begin
                next_rdata = {8'h00, resp};
            end else if (hit_warn && all_ph) begin
                next_rdata = {`OCF_WARN_EXP, sum_qa};
            end else if (hit_warn) begin
                next_rdata = {`OCF_WARN_EXP, 3'h0, lim_vec[ph_idx*8 +: 8]};
            end else if (hit_ot) begin
                next_rdata = ot_raw;
            end
        end
    end

    // Read data and its strobe
    always_ff @(posedge CLK) begin
        if (RESET) begin
            RDATA <= 16'h0000;
            RDATA_VALID <= 1'b0;
        end else begin
            RDATA <= next_rdata;
            RDATA_VALID <= rd;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Fault raises all three status bits
    a_fault_status: assert property (@(posedge CLK) disable iff (RESET)
        oc_fault |=> (STAT_BYTE_IOUT_OC && STAT_WORD_IOUT && STAT_IOUT_OCF && NOTIFY_HOST))
        else $error("fault status not set");

    // Warning raises its status bits
    a_warn_status: assert property (@(posedge CLK) disable iff (RESET)
        warn_trip[0] |=> (STAT_BYTE_NONE && STAT_IOUT_OCW && STAT_WORD_IOUT && NOTIFY_HOST))
        else $error("warning status not set");

    // Refused size leaves the register alone
    a_bad_write: assert property (@(posedge CLK) disable iff (RESET)
        (CMD_VALID && CMD_WORD && hit_resp && !NVM_RESTORE)
        |=> STAT_CML_DATA ##0 $stable(resp))
        else $error("invalid write not flagged");

    // Low limit applied as the floor step
    a_floor_eight: assert property (@(posedge CLK) disable iff (RESET)
        (warn_wr && !NVM_RESTORE && all_ph && wr_qa < 8'h20) |=> ##1
        PHASE_WARN_STEP[4:0] == `OCF_STEP_MIN)
        else $error("low limit not floored");

    // Temperature flag held until cleared
    a_sticky_temp: assert property (@(posedge CLK) disable iff (RESET)
        (STAT_TEMP_OTF && !CLEAR_FAULTS) |=> STAT_TEMP_OTF)
        else $error("status dropped without clear");

    // Temperature at the limit trips
    a_temp_trip: assert property (@(posedge CLK) disable iff (RESET)
        ($signed(DIE_TEMP) == 12'(lin_to_deg(ot_raw))) |=> STAT_TEMP_OTF)
        else $error("temperature limit missed");

    // Clear with no live event drops the flags
    a_clear_status: assert property (@(posedge CLK) disable iff (RESET)
        (CLEAR_FAULTS && !oc_fault && !ot_fault && !invalid)
        |=> !(STAT_IOUT_OCF || STAT_TEMP_OTF || STAT_CML_DATA))
        else $error("status not cleared");

    // Every read gets its answer strobe
    a_read_answer: assert property (@(posedge CLK) disable iff (RESET)
        (CMD_VALID && !CMD_WRITE) |=> RDATA_VALID)
        else $error("read answer missing");

    // Latched output stays off while enabled
    a_latch_hold: assert property (@(posedge CLK) disable iff (RESET)
        (LATCHED_OFF && ENABLE) |=> LATCHED_OFF)
        else $error("latched output restarted");

    // Temperature fault raises its flag and notifies
    a_temp_status: assert property (@(posedge CLK) disable iff (RESET)
        ot_fault |=> (STAT_TEMP_OTF && NOTIFY_HOST))
        else $error("temperature status not set");
endmodule : ocf_top

// >>> ocf_top_bench.sv
`timescale 1ns/10ps
module ocf_top_bench import ocf_pkg::*;;
    logic CLK = 1'b0, RESET, CLEAR_FAULTS, NVM_RESTORE, PWM_TICK, ENABLE, pv;
    logic CMD_VALID, CMD_WRITE, CMD_WORD, RDATA_VALID, POWER_ON, LATCHED_OFF;
    logic [7:0] CMD_CODE, PHASE, NVM_RESP;
    logic [15:0] CMD_WDATA, RDATA, NVM_WARN, r;
    logic [43:0] PHASE_IOUT;
    logic [10:0] CURRENT_FAULT_THRESHOLD;
    logic [11:0] DIE_TEMP;
    logic STAT_BYTE_IOUT_OC, STAT_BYTE_NONE, STAT_WORD_IOUT, STAT_IOUT_OCF;
    logic STAT_IOUT_OCW, STAT_TEMP_OTF, STAT_CML_DATA, NOTIFY_HOST;
    logic [19:0] PHASE_WARN_STEP;
    logic [3:0] PHASE_WARN;
    int seed, fails, comparisons, i, m, n, k, pc;
    int qa[4];
    ocf_top #(.NUM_PHASES(4), .TON_RISE_CYCLES(20)) ocf_top_i (
        .CLK, .RESET, .CMD_VALID, .CMD_WRITE, .CMD_WORD, .CMD_CODE, .PHASE, .CMD_WDATA,
        .RDATA, .RDATA_VALID, .CLEAR_FAULTS, .NVM_RESTORE, .NVM_RESP, .NVM_WARN,
        .NVM_OT(16'h007d), .PWM_TICK, .ENABLE, .PHASE_IOUT, .CURRENT_FAULT_THRESHOLD,
        .DIE_TEMP, .POWER_ON, .LATCHED_OFF, .PHASE_WARN_STEP, .PHASE_WARN,
        .STAT_BYTE_IOUT_OC, .STAT_BYTE_NONE, .STAT_WORD_IOUT, .STAT_IOUT_OCF,
        .STAT_IOUT_OCW, .STAT_TEMP_OTF, .STAT_CML_DATA, .NOTIFY_HOST);
    ocf_host ocf_host_i (.clk(CLK), .valid(CMD_VALID), .write(CMD_WRITE), .word(CMD_WORD),
        .code(CMD_CODE), .phase(PHASE), .wdata(CMD_WDATA), .rdata(RDATA),
        .rdata_valid(RDATA_VALID));
    // Clock and a switching tick every fourth cycle
    always #10 CLK = ~CLK;
    always @(negedge CLK) begin
        pc <= pc + 1;
        PWM_TICK <= (pc % 4 == 0);
    end
    // Model threshold step: 2 A units, floor of 8 A, rounded up
    function automatic int step_of(input int q);
        return (q < 32) ? 4 : (q + 7) / 8;
    endfunction : step_of
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic flag(input logic g, input logic e);
        check({15'h0000, g}, {15'h0000, e});
    endtask : flag
    task automatic cyc(input int c);
        repeat (c) @(negedge CLK);
    endtask : cyc
    task automatic wr(input logic wd, input logic [7:0] c, input logic [7:0] p,
        input logic [15:0] d);
        ocf_host_i.xfer(1'b1, wd, c, p, d, r);
    endtask : wr
    // Read warning limit of one phase and its applied step
    task automatic rdw(input int p, input logic [15:0] e);
        ocf_host_i.xfer(1'b0, 1'b1, 8'h4a, p[7:0], 16'h0000, r);
        check(r, e);
        if (p < 4) check({11'h000, PHASE_WARN_STEP[p*5+:5]}, 16'(step_of(qa[p])));
    endtask : rdw
    task automatic clr_f;
        CLEAR_FAULTS = 1'b1;
        cyc(1);
        CLEAR_FAULTS = 1'b0;
        cyc(2);
    endtask : clr_f
    task automatic final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    // Watchdog
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        final_report;
    end
    // Main sequence
    initial begin
        seed = 32'h1f15;
        {RESET, CLEAR_FAULTS, NVM_RESTORE, ENABLE} = 4'b1000;
        {NVM_RESP, NVM_WARN, PHASE_IOUT, DIE_TEMP, fails, comparisons} = '0;
        CURRENT_FAULT_THRESHOLD = 11'h07ff;
        cyc(2);
        RESET = 1'b0;
        cyc(2);
        ocf_host_i.xfer(1'b0, 1'b0, 8'h47, 8'h00, 16'h0000, r);
        check(r, 16'h00c0);
        ocf_host_i.xfer(1'b0, 1'b1, 8'h4f, 8'h00, 16'h0000, r);
        check(r, 16'h007d);
        for (i = 0; i < 4; i++) begin
            qa[i] = 160;
            rdw(i, 16'hf0a0);
        end
        wr(1'b0, 8'h47, 8'h00, 16'h003f);
        wr(1'b1, 8'h47, 8'h00, 16'h00c0);
        cyc(2);
        flag(STAT_CML_DATA, 1'b1);
        flag(NOTIFY_HOST, 1'b1);
        ocf_host_i.xfer(1'b0, 1'b0, 8'h47, 8'h00, 16'h0000, r);
        check(r, 16'h0038);
        clr_f;
        flag(NOTIFY_HOST, 1'b0);
        // Warning limits: edges and random values per phase
        for (n = 0; n < 10; n++) begin
            m = (n == 0) ? 16 : (n == 1) ? 248 : {$random(seed)} % 249;
            i = n % 4;
            wr(1'b1, 8'h4a, i[7:0], 16'hf000 | m[15:0]);
            qa[i] = m;
            cyc(2);
            rdw(i, 16'hf000 | m[15:0]);
        end
        wr(1'b1, 8'h4a, 8'h01, 16'hf0f9);
        cyc(2);
        flag(STAT_CML_DATA, 1'b1);
        rdw(1, 16'hf000 | 16'(qa[1]));
        clr_f;
        wr(1'b1, 8'h4a, 8'hff, 16'hf079);
        for (i = 0; i < 4; i++) qa[i] = 31;
        cyc(2);
        rdw(255, 16'hf07c);
        rdw(3, 16'hf01f);
        PHASE_IOUT = {11'h01f, 11'h020, 11'h01f, 11'h01f};
        cyc(2);
        check({12'h000, PHASE_WARN}, 16'h0004);
        flag(STAT_BYTE_NONE, 1'b1);
        flag(STAT_WORD_IOUT, 1'b1);
        flag(STAT_BYTE_IOUT_OC, 1'b0);
        PHASE_IOUT = '0;
        cyc(2);
        flag(STAT_IOUT_OCW, 1'b1);
        clr_f;
        flag(STAT_IOUT_OCW, 1'b0);
        wr(1'b1, 8'h4f, 8'h00, 16'h0050);
        DIE_TEMP = 12'h04f;
        cyc(2);
        flag(STAT_TEMP_OTF, 1'b0);
        DIE_TEMP = 12'h050;
        cyc(2);
        flag(STAT_TEMP_OTF, 1'b1);
        DIE_TEMP = 12'h000;
        clr_f;
        // Delayed shutdown for every delay code, no retry
        CURRENT_FAULT_THRESHOLD = 11'h064;
        for (i = 7; i >= 0; i--) begin
            NVM_RESP = {5'b10000, i[2:0]};
            NVM_WARN = 16'he0a5;
            NVM_RESTORE = 1'b1;
            cyc(1);
            NVM_RESTORE = 1'b0;
            ENABLE = 1'b1;
            cyc(30);
            @(posedge CLK iff PWM_TICK);
            @(negedge CLK);
            PHASE_IOUT[10:0] = 11'h064;
            n = 0;
            repeat (40) @(posedge CLK) if (!LATCHED_OFF && PWM_TICK) n++;
            @(negedge CLK);
            check(16'(n), 16'(i < 2 ? 1 : i < 5 ? 3 : 7));
            flag(LATCHED_OFF, 1'b1);
            flag(STAT_IOUT_OCF, 1'b1);
            flag(STAT_BYTE_IOUT_OC, 1'b1);
            ENABLE = 1'b0;
            PHASE_IOUT = '0;
            cyc(2);
            clr_f;
        end
        qa[1] = 41;
        rdw(1, 16'hf029);
        // Every action code with two retries, then endless and no retry
        PHASE_IOUT[10:0] = 11'h064;
        for (n = 0; n < 6; n++) begin
            m = (n < 4) ? n : 3;
            i = (n < 4) ? 2 : (n == 4) ? 7 : 0;
            wr(1'b0, 8'h47, 8'h00, {8'h00, m[1:0], i[2:0], 3'b000});
            ENABLE = 1'b1;
            k = 0;
            pv = 1'b0;
            repeat (300) begin
                @(negedge CLK);
                if (POWER_ON && !pv) k++;
                pv = POWER_ON;
            end
            if (n != 4) begin
                check(16'(k), 16'(m < 2 || i == 0 ? 1 : 3));
                flag(LATCHED_OFF, m > 1);
                flag(POWER_ON, m < 2);
            end else begin
                flag(k > 7, 1'b1);
                flag(LATCHED_OFF, 1'b0);
            end
            ENABLE = 1'b0;
            cyc(2);
            clr_f;
        end
        final_report;
    end
endmodule : ocf_top_bench
